// >>> design/irqsc_collector.sv
// Top of the interrupt status collector: upper interrupt bits, per-port ADC arrival and
// driver overcurrent status, the summary bits and the active-low interrupt output.
// Assumes a register read port from the serial interface logic on mclk, analog comparator
// levels arriving asynchronously, and the mask and bits 0, 2, 3, 4 supplied from outside.
//
// Notes on behaviour
// - Bits 8:6: local sensor high, low, new.
// - Bits 11:9: first remote sensor, same arrangement.
// - Bits 14:12: second remote sensor, same arrangement.
// - Compare readings against 12-bit high, low limits.
// - Interrupt register read clears temperature, supply bits.
// - Bit 15 set when port supply drops low.
// - ADC arrival bits: ports 0-15 low, 16-19 high.
// - New result written sets port arrival bit.
// - With averaging, set only after full sample set.
// - Masks never gate arrival status recording.
// - Arrival clear: interrupt read, then both halves.
// - Driver current detector trip sets overcurrent bit.
// - Overcurrent bits: ports 0-15 low, 16-19 high.
// - Masks never gate overcurrent status recording.
// - Overcurrent clear: interrupt read, then both halves.
// - Bit 1 set on any new ADC result.
// - Bit 5 set on any driver overcurrent.
// - Interrupt pin low while unmasked bit set.
`timescale 1ns/1ps
module irqsc_collector #(
   parameter int PORTS = irqsc_pkg::PORTS
) (
   input  wire logic                                     mclk,
   input  wire logic                                     rst,
   input  wire irqsc_pkg::irqsc_sample_t                 local_sample,
   input  wire irqsc_pkg::irqsc_sample_t                 remote1_sample,
   input  wire irqsc_pkg::irqsc_sample_t                 remote2_sample,
   input  wire irqsc_pkg::irqsc_limits_t                 local_temp_limits,
   input  wire irqsc_pkg::irqsc_limits_t                 remote1_limits,
   input  wire irqsc_pkg::irqsc_limits_t                 remote2_limits,
   input  wire logic                                     supply_low_pin,
   input  wire logic [PORTS-1:0]                         overcurrent_pin,
   input  wire logic [PORTS-1:0]                         adc_conv_done,
   input  wire logic [PORTS-1:0][irqsc_pkg::AVG_W-1:0]   adc_avg_log2,
   input  wire logic [irqsc_pkg::REG_W-1:0]              foreign_flags,
   input  wire logic [irqsc_pkg::REG_W-1:0]              irq_mask,
   input  wire logic                                     rd_stb,
   input  wire irqsc_pkg::irqsc_sel_t                    rd_sel,
   output logic [irqsc_pkg::REG_W-1:0]                   rd_data_r,
   output logic                                          rd_valid_r,
   output logic [PORTS-1:0]                              adc_result_load_r,
   output logic                                          int_n_r
);
   localparam int REG_W = irqsc_pkg::REG_W;
   localparam int CNT_W = irqsc_pkg::AVG_CNT_W;

   initial begin
      if (PORTS != irqsc_pkg::LOW_W + irqsc_pkg::HIGH_W) begin
         $error("PORTS must equal the two status halves combined");
      end
   end

   // Number of conversions to gather for an averaging setting; zero means one sample.
   function automatic logic [CNT_W-1:0] avg_target(input logic [irqsc_pkg::AVG_W-1:0] n);
      avg_target = CNT_W'(1) << n;
   endfunction : avg_target

   // Two-stage synchronisers for the analog comparator levels.
   logic             supply_meta_r;
   logic             supply_sync_r;
   logic [PORTS-1:0] oc_meta_r;
   logic [PORTS-1:0] oc_sync_r;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         supply_meta_r <= 1'b0;
         supply_sync_r <= 1'b0;
         oc_meta_r     <= '0;
         oc_sync_r     <= '0;
      end else begin
         supply_meta_r <= supply_low_pin;
         supply_sync_r <= supply_meta_r;
         oc_meta_r     <= overcurrent_pin;
         oc_sync_r     <= oc_meta_r;
      end
   end

   // Read decode.
   wire logic rd_irq_w    = rd_stb && rd_sel == irqsc_pkg::SEL_IRQ;
   wire logic rd_adc_lo_w = rd_stb && rd_sel == irqsc_pkg::SEL_ADC_LO;
   wire logic rd_adc_hi_w = rd_stb && rd_sel == irqsc_pkg::SEL_ADC_HI;
   wire logic rd_oc_lo_w  = rd_stb && rd_sel == irqsc_pkg::SEL_OC_LO;
   wire logic rd_oc_hi_w  = rd_stb && rd_sel == irqsc_pkg::SEL_OC_HI;

   // Temperature event generators.
   logic [2:0] local_temp_events;
   logic [2:0] remote1_temp_events;
   logic [2:0] remote2_temp_events;

   irqsc_temp_check u_local (
      .mclk     (mclk),
      .rst      (rst),
      .sample   (local_sample),
      .limits   (local_temp_limits),
      .events_r (local_temp_events)
   );

   irqsc_temp_check u_remote1 (
      .mclk     (mclk),
      .rst      (rst),
      .sample   (remote1_sample),
      .limits   (remote1_limits),
      .events_r (remote1_temp_events)
   );

   irqsc_temp_check u_remote2 (
      .mclk     (mclk),
      .rst      (rst),
      .sample   (remote2_sample),
      .limits   (remote2_limits),
      .events_r (remote2_temp_events)
   );

   // Sticky upper interrupt bits 15:6, cleared by reading the interrupt register.
   localparam int UP_W = REG_W - irqsc_pkg::UPPER_LSB;

   logic [UP_W-1:0] upper_r;
   logic [UP_W-1:0] upper_nxt;
   wire  logic [UP_W-1:0] upper_set_w = {supply_sync_r,
                                         remote2_temp_events,
                                         remote1_temp_events,
                                         local_temp_events};

   // Set wins over the read clear so an event that lands on the read is kept.
   assign upper_nxt = (upper_r & ~{UP_W{rd_irq_w}}) | upper_set_w;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         upper_r <= irqsc_pkg::FLAGS_RESET[REG_W-1:irqsc_pkg::UPPER_LSB];
      end else begin
         upper_r <= upper_nxt;
      end
   end

   // Averaging: a port's result register loads only after its full sample set.
   logic [PORTS-1:0][CNT_W-1:0] avg_cnt_r;

   for (genvar p = 0; p < PORTS; p++) begin : g_avg
      wire logic [CNT_W-1:0] cnt_inc_w = avg_cnt_r[p] + CNT_W'(1);
      wire logic             full_w    = cnt_inc_w >= avg_target(adc_avg_log2[p]);

      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            avg_cnt_r[p]         <= '0;
            adc_result_load_r[p] <= 1'b0;
         end else begin
            adc_result_load_r[p] <= adc_conv_done[p] && full_w;
            if (adc_conv_done[p]) begin
               avg_cnt_r[p] <= full_w ? '0 : cnt_inc_w;
            end
         end
      end
   end

   // Per-port status: recorded with no regard to the mask.
   logic [PORTS-1:0] adc_arrival_status;
   logic [PORTS-1:0] driver_overcurrent_status;
   logic             adc_data_ready_summary;
   logic             overcurrent_summary;

   irqsc_port_status u_adc_status (
      .mclk      (mclk),
      .rst       (rst),
      .set_vec   (adc_result_load_r),
      .rd_irq    (rd_irq_w),
      .rd_lo     (rd_adc_lo_w),
      .rd_hi     (rd_adc_hi_w),
      .status_r  (adc_arrival_status),
      .summary_r (adc_data_ready_summary)
   );

   irqsc_port_status u_oc_status (
      .mclk      (mclk),
      .rst       (rst),
      .set_vec   (oc_sync_r),
      .rd_irq    (rd_irq_w),
      .rd_lo     (rd_oc_lo_w),
      .rd_hi     (rd_oc_hi_w),
      .status_r  (driver_overcurrent_status),
      .summary_r (overcurrent_summary)
   );

   // Full interrupt register image.
   logic [REG_W-1:0] irq_word;

   always_comb begin
      irq_word = foreign_flags & irqsc_pkg::FOREIGN_MASK;
      irq_word[irqsc_pkg::BIT_DATA_READY]  = adc_data_ready_summary;
      irq_word[irqsc_pkg::BIT_OVERCURRENT] = overcurrent_summary;
      irq_word[REG_W-1:irqsc_pkg::UPPER_LSB] = upper_r;
   end

   wire logic [REG_W-1:0] adc_lo_word = adc_arrival_status[irqsc_pkg::LOW_W-1:0];
   wire logic [REG_W-1:0] adc_hi_word = {{(REG_W-irqsc_pkg::HIGH_W){1'b0}},
                                         adc_arrival_status[PORTS-1:irqsc_pkg::LOW_W]};
   wire logic [REG_W-1:0] oc_lo_word  = driver_overcurrent_status[irqsc_pkg::LOW_W-1:0];
   wire logic [REG_W-1:0] oc_hi_word  = {{(REG_W-irqsc_pkg::HIGH_W){1'b0}},
                                         driver_overcurrent_status[PORTS-1:irqsc_pkg::LOW_W]};

   logic [REG_W-1:0] rd_mux;

   always_comb begin
      case (rd_sel)
         irqsc_pkg::SEL_IRQ:    rd_mux = irq_word;
         irqsc_pkg::SEL_ADC_LO: rd_mux = adc_lo_word;
         irqsc_pkg::SEL_ADC_HI: rd_mux = adc_hi_word;
         irqsc_pkg::SEL_OC_LO:  rd_mux = oc_lo_word;
         irqsc_pkg::SEL_OC_HI:  rd_mux = oc_hi_word;
         default:               rd_mux = '0;
      endcase
   end

   // Read data is captured before the clear takes effect on the same edge.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data_r  <= '0;
         rd_valid_r <= 1'b0;
         int_n_r    <= 1'b1;
      end else begin
         rd_valid_r <= rd_stb;
         if (rd_stb) begin
            rd_data_r <= rd_mux;
         end
         int_n_r <= ~|(irq_word & ~irq_mask);
      end
   end

   a_supply_sets_bit: assert property (@(posedge mclk) disable iff (rst)
      supply_low_pin ##1 supply_low_pin |=> ##1
         upper_r[irqsc_pkg::BIT_SUPPLY_LOW-irqsc_pkg::UPPER_LSB])
      else $error("supply drop not recorded in bit 15");

   a_irq_read_clears: assert property (@(posedge mclk) disable iff (rst)
      rd_irq_w && upper_set_w == '0 |=> upper_r == '0)
      else $error("interrupt read did not clear the upper bits");

   a_upper_sticky: assert property (@(posedge mclk) disable iff (rst)
      !rd_irq_w && upper_r[0] |=> upper_r[0])
      else $error("local new-reading bit dropped without a read");

   a_avg_off_load: assert property (@(posedge mclk) disable iff (rst)
      adc_conv_done[0] && adc_avg_log2[0] == irqsc_pkg::AVG_W'(0) |=> adc_result_load_r[0])
      else $error("unaveraged conversion did not load the result");

   a_arrival_after_load: assert property (@(posedge mclk) disable iff (rst)
      adc_result_load_r[0] |=> adc_arrival_status[0] && adc_data_ready_summary)
      else $error("result load did not set arrival status");

   a_oc_latched: assert property (@(posedge mclk) disable iff (rst)
      overcurrent_pin[0] [*3] |=> driver_overcurrent_status[0] && overcurrent_summary)
      else $error("driver trip not recorded");

   a_int_pin_level: assert property (@(posedge mclk) disable iff (rst)
      |(irq_word & ~irq_mask) |=> !int_n_r)
      else $error("unmasked interrupt bit did not pull the pin low");

   a_int_pin_idle: assert property (@(posedge mclk) disable iff (rst)
      (irq_word & ~irq_mask) == '0 |=> int_n_r)
      else $error("pin low with no unmasked bit");

   a_read_answer: assert property (@(posedge mclk) disable iff (rst)
      rd_stb |=> rd_valid_r && rd_data_r == $past(rd_mux))
      else $error("read answer missing or wrong");
endmodule : irqsc_collector

// >>> design/irqsc_pkg.sv
// Shared constants and types for the interrupt status collector.
// Assumes one system clock; every user of this package qualifies names with irqsc_pkg::.
package irqsc_pkg;
   localparam int PORTS      = 20;
   localparam int LOW_W      = 16;
   localparam int HIGH_W     = 4;
   localparam int REG_W      = 16;
   localparam int TEMP_W     = 12;
   localparam int AVG_W      = 3;
   localparam int AVG_CNT_W  = 8;

   // Interrupt register bit positions owned by this block.
   localparam int BIT_DATA_READY   = 1;
   localparam int BIT_OVERCURRENT  = 5;
   localparam int BIT_LOCAL_LSB    = 6;
   localparam int BIT_REMOTE1_LSB  = 9;
   localparam int BIT_REMOTE2_LSB  = 12;
   localparam int BIT_SUPPLY_LOW   = 15;
   localparam int UPPER_LSB        = 6;

   // Order of the three events inside each sensor triple.
   localparam int EV_NEW  = 0;
   localparam int EV_LOW  = 1;
   localparam int EV_HIGH = 2;

   // Interrupt bits 0, 2, 3 and 4 are kept by neighbouring logic and only merged here.
   localparam logic [REG_W-1:0] FOREIGN_MASK = 16'h001D;
   localparam logic [REG_W-1:0] FLAGS_RESET  = 16'h0000;

   typedef enum logic [2:0] {
      SEL_IRQ,
      SEL_ADC_LO,
      SEL_ADC_HI,
      SEL_OC_LO,
      SEL_OC_HI
   } irqsc_sel_t;

   typedef enum logic [1:0] {
      TRK_IDLE,
      TRK_ARMED,
      TRK_GOT_LO,
      TRK_GOT_HI
   } irqsc_trk_state_t;

   typedef struct packed {
      logic              valid;
      logic [TEMP_W-1:0] value;
   } irqsc_sample_t;

   typedef struct packed {
      logic [TEMP_W-1:0] high;
      logic [TEMP_W-1:0] low;
   } irqsc_limits_t;
endpackage : irqsc_pkg

// >>> design/irqsc_temp_check.sv
// One temperature sensor's event generator: new-reading, under-limit and over-limit pulses.
// Assumes samples and limits come from logic on mclk; readings are two's complement.
`timescale 1ns/1ps
module irqsc_temp_check (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire irqsc_pkg::irqsc_sample_t sample,
   input  wire irqsc_pkg::irqsc_limits_t limits,
   output logic [2:0]                    events_r
);
   wire logic over_w  = $signed(sample.value) > $signed(limits.high);
   wire logic under_w = $signed(sample.value) < $signed(limits.low);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         events_r <= 3'h0;
      end else begin
         events_r[irqsc_pkg::EV_NEW]  <= sample.valid;
         events_r[irqsc_pkg::EV_LOW]  <= sample.valid & under_w;
         events_r[irqsc_pkg::EV_HIGH] <= sample.valid & over_w;
      end
   end

   a_over_limit: assert property (@(posedge mclk) disable iff (rst)
      sample.valid && $signed(sample.value) > $signed(limits.high)
      |=> events_r[irqsc_pkg::EV_HIGH])
      else $error("over-limit reading did not raise the high event");

   a_no_event_idle: assert property (@(posedge mclk) disable iff (rst)
      !sample.valid |=> events_r == 3'h0)
      else $error("temperature event without a reading");
endmodule : irqsc_temp_check

// >>> design/irqsc_port_status.sv
// Per-port sticky status with its summary bit, cleared only by the read sequence:
// interrupt register first, then both status halves in either order.
// Assumes at most one register read per cycle.
`timescale 1ns/1ps
module irqsc_port_status #(
   parameter int LOW_W  = irqsc_pkg::LOW_W,
   parameter int HIGH_W = irqsc_pkg::HIGH_W
) (
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic [LOW_W+HIGH_W-1:0] set_vec,
   input  wire logic                    rd_irq,
   input  wire logic                    rd_lo,
   input  wire logic                    rd_hi,
   output logic [LOW_W+HIGH_W-1:0]      status_r,
   output logic                         summary_r
);
   localparam int W = LOW_W + HIGH_W;

   irqsc_pkg::irqsc_trk_state_t state_r;
   irqsc_pkg::irqsc_trk_state_t state_nxt;

   wire logic clear_w = (state_r == irqsc_pkg::TRK_GOT_LO && rd_hi)
                     || (state_r == irqsc_pkg::TRK_GOT_HI && rd_lo);

   always_comb begin
      state_nxt = state_r;
      if (rd_irq) begin
         state_nxt = irqsc_pkg::TRK_ARMED;
      end else begin
         case (state_r)
            irqsc_pkg::TRK_ARMED: begin
               if (rd_lo) state_nxt = irqsc_pkg::TRK_GOT_LO;
               if (rd_hi) state_nxt = irqsc_pkg::TRK_GOT_HI;
            end
            irqsc_pkg::TRK_GOT_LO: begin
               if (rd_hi) state_nxt = irqsc_pkg::TRK_IDLE;
            end
            irqsc_pkg::TRK_GOT_HI: begin
               if (rd_lo) state_nxt = irqsc_pkg::TRK_IDLE;
            end
            default: state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r   <= irqsc_pkg::TRK_IDLE;
         status_r  <= '0;
         summary_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         status_r  <= (status_r & ~{W{clear_w}}) | set_vec;
         summary_r <= (summary_r & ~clear_w) | (|set_vec);
      end
   end

   a_clear_needs_seq: assert property (@(posedge mclk) disable iff (rst)
      state_r == irqsc_pkg::TRK_IDLE && !rd_irq
      |=> ($past(status_r) & ~status_r) == '0 && !$fell(summary_r))
      else $error("status cleared without the interrupt read first");

   a_set_wins: assert property (@(posedge mclk) disable iff (rst)
      |set_vec |=> summary_r)
      else $error("event lost against a read clear");
endmodule : irqsc_port_status

// >>> tb/irqsc_host_model.sv
// Host side of the register read port: one read at a time through the strobe.
// Assumes the collector answers with rd_valid_r one cycle after the strobe.
`timescale 1ns/1ps
module irqsc_host_model (
   input  wire logic                        mclk,
   input  wire logic [irqsc_pkg::REG_W-1:0] rd_data_r,
   input  wire logic                        rd_valid_r,
   output logic                             rd_stb,
   output irqsc_pkg::irqsc_sel_t            rd_sel
);
   initial begin
      rd_stb = 1'b0;
      rd_sel = irqsc_pkg::SEL_IRQ;
   end

   // Callers read in any order; the fixed read sequences always take the interrupt word before the status halves.
   task automatic read_reg(input logic [2:0] sel, output logic [15:0] data, output logic ok);
      ok = 1'b0;
      data = 16'h0;
      @(posedge mclk);
      rd_stb <= 1'b1;
      rd_sel <= irqsc_pkg::irqsc_sel_t'(sel);
      @(posedge mclk);
      rd_stb <= 1'b0;
      // The idle select wanders so that a design sampling it without the strobe is caught.
      rd_sel <= irqsc_pkg::irqsc_sel_t'(~sel);
      for (int n = 0; n < 4 && !ok; n++) begin
         @(posedge mclk);
         if (rd_valid_r === 1'b1) begin
            data = rd_data_r;
            ok = 1'b1;
         end
      end
   endtask : read_reg
endmodule : irqsc_host_model

// >>> tb/irq_status_collector_tb.sv
// Self-checking bench for the interrupt status collector against a behavioural model.
// Assumes the design package, the design and the host model are compiled first.
`timescale 1ns/1ps
module irq_status_collector_tb;
   localparam int NP = irqsc_pkg::PORTS;
   logic                                mclk;
   logic                                rst;
   irqsc_pkg::irqsc_sample_t            smp [3];
   irqsc_pkg::irqsc_limits_t            lim [3];
   logic                                supply_low_pin;
   logic [NP-1:0]                       oc_pin;
   logic [NP-1:0]                       conv_done;
   logic [NP-1:0][irqsc_pkg::AVG_W-1:0] avg;
   logic [15:0]                         foreign;
   logic [15:0]                         mask;
   logic                                rd_stb;
   irqsc_pkg::irqsc_sel_t               rd_sel;
   logic [15:0]                         rd_data_r;
   logic                                rd_valid_r;
   logic                                int_n_r;
   int                                  mismatches;
   int                                  comparisons;
   logic [31:0]                         seed;
   logic [15:0]                         m_up;
   logic [NP-1:0]                       m_adc;
   logic [NP-1:0]                       m_oc;
   int                                  adc_st;
   int                                  oc_st;
   int                                  cnt [NP];
   logic [NP-1:0]                       load_w;
   int                                  loads_exp;
   int                                  loads_got;

   irqsc_collector #(.PORTS(NP)) dut (
      .mclk(mclk), .rst(rst),
      .local_sample(smp[0]), .remote1_sample(smp[1]), .remote2_sample(smp[2]),
      .local_temp_limits(lim[0]), .remote1_limits(lim[1]), .remote2_limits(lim[2]),
      .supply_low_pin(supply_low_pin), .overcurrent_pin(oc_pin),
      .adc_conv_done(conv_done), .adc_avg_log2(avg),
      .foreign_flags(foreign), .irq_mask(mask),
      .rd_stb(rd_stb), .rd_sel(rd_sel), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .adc_result_load_r(load_w), .int_n_r(int_n_r)
   );

   // Every result load pulse is counted once; the model counts completed sample sets.
   always @(posedge mclk) begin
      if (!rst) begin
         loads_got <= loads_got + $countones(load_w);
      end
   end

   irqsc_host_model host (
      .mclk(mclk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .rd_stb(rd_stb), .rd_sel(rd_sel)
   );

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Summary bits mirror the port status: they set and clear together with it.
   function automatic logic [15:0] m_word();
      return m_up | (foreign & irqsc_pkg::FOREIGN_MASK) | {10'h0, |m_oc, 3'h0, |m_adc, 1'b0};
   endfunction : m_word

   function automatic logic [15:0] tev(input logic [11:0] v, input irqsc_pkg::irqsc_limits_t l);
      return {13'h0, $signed(v) > $signed(l.high), $signed(v) < $signed(l.low), 1'b1};
   endfunction : tev

   // Tracker: 1 armed by an interrupt read, 2 low half seen, 3 high half seen.
   function automatic void advance(inout int st, inout logic [NP-1:0] v, input int half);
      if (st == 1) begin
         st = half;
      end else if (st != 0 && st != half) begin
         st = 0;
         v = '0;
      end
   endfunction : advance

   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_pin(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : check_pin

   task automatic do_read(input logic [2:0] sel);
      logic [15:0] got;
      logic [15:0] exp;
      logic        ok;
      case (sel)
         3'd0: begin
            exp = m_word();
            m_up = 16'h0;
            adc_st = 1;
            oc_st = 1;
         end
         3'd1: exp = m_adc[15:0];
         3'd2: exp = {12'h0, m_adc[19:16]};
         3'd3: exp = m_oc[15:0];
         3'd4: exp = {12'h0, m_oc[19:16]};
         default: exp = 16'h0;
      endcase
      if (sel == 3'd1 || sel == 3'd2) advance(adc_st, m_adc, int'(sel) + 1);
      if (sel == 3'd3 || sel == 3'd4) advance(oc_st, m_oc, int'(sel) - 1);
      host.read_reg(sel, got, ok);
      check_pin("read answer", 1'b1, ok);
      check_word("read data", exp, got);
   endtask : do_read

   task automatic round();
      logic [31:0] r;
      logic [11:0] v12;
      @(posedge mclk);
      mask <= 16'(rnd());
      foreign <= 16'(rnd());
      for (int i = 0; i < 3; i++) lim[i] <= {12'(rnd()), 12'(rnd())};
      @(posedge mclk);
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         // Half of the readings sit exactly on a limit, where that limit's own event may not fire.
         v12 = r[30] ? (r[29] ? lim[i].high : lim[i].low) : r[11:0];
         smp[i] <= '{valid: r[31], value: v12};
         if (r[31]) m_up = m_up | (tev(v12, lim[i]) << (irqsc_pkg::BIT_LOCAL_LSB + 3 * i));
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         for (int i = 0; i < 3; i++) smp[i].valid <= 1'b0;
         r = rnd() & rnd();
         conv_done <= r[NP-1:0];
         for (int p = 0; p < NP; p++) begin
            if (r[p]) cnt[p]++;
            if (cnt[p] == (1 << avg[p])) begin
               cnt[p] = 0;
               m_adc[p] = 1'b1;
               loads_exp++;
            end
         end
      end
      @(posedge mclk);
      conv_done <= '0;
      r = rnd() & rnd() & rnd();
      oc_pin <= r[NP-1:0];
      m_oc = m_oc | r[NP-1:0];
      supply_low_pin <= r[31];
      if (r[31]) m_up[irqsc_pkg::BIT_SUPPLY_LOW] = 1'b1;
      repeat (4) @(posedge mclk);
      oc_pin <= '0;
      supply_low_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      check_pin("int_n_r", ~|(m_word() & ~mask), int_n_r);
      for (int k = 0; k < 10; k++) do_read(3'(rnd() % 6));
      do_read(3'd0);
      do_read(3'd3);
      do_read(3'd4);
      do_read(3'd0);
      do_read(3'd2);
      do_read(3'd1);
      repeat (3) @(posedge mclk);
      check_pin("int_n_r", ~|(m_word() & ~mask), int_n_r);
   endtask : round

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   initial begin
      mismatches = 0;
      comparisons = 0;
      seed = 32'd17431;
      rst = 1'b1;
      supply_low_pin = 1'b0;
      oc_pin = '0;
      conv_done = '0;
      foreign = 16'h0;
      mask = 16'h0;
      m_up = 16'h0;
      m_adc = '0;
      m_oc = '0;
      adc_st = 0;
      oc_st = 0;
      loads_exp = 0;
      loads_got = 0;
      for (int i = 0; i < 3; i++) begin
         smp[i] = '0;
         lim[i] = '0;
      end
      for (int p = 0; p < NP; p++) begin
         avg[p] = 3'(rnd() % 3);
         cnt[p] = 0;
      end
      repeat (3) @(posedge mclk);
      check_pin("int_n_r in reset", 1'b1, int_n_r);
      rst <= 1'b0;
      for (int s = 0; s < 6; s++) do_read(3'(s));
      for (int k = 0; k < 8; k++) round();
      check_word("result loads", 16'(loads_exp), 16'(loads_got));
      final_report();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("unexpected watchdog: expected done seen running");
      final_report();
   end
endmodule : irq_status_collector_tb
